// file: rtl/ppcm_top.sv
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
module ppcm_top
  import ppcm_pkg::*;
#(
  parameter int NUM_PINS = PIN_COUNT
) (
  input  wire logic                                mclk,
  input  wire logic                                rst_n,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [ADDR_W-1:0]                   paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [ALT_COUNT-1:0][NUM_PINS-1:0]  alt_en,
  input  wire logic [ALT_COUNT-1:0][NUM_PINS-1:0]  alt_oe,
  input  wire logic [ALT_COUNT-1:0][NUM_PINS-1:0]  alt_out,
  output logic      [NUM_PINS-1:0]                 periph_in,
  input  wire logic [NUM_PINS-1:0]                 pad_in,
  output logic      [NUM_PINS-1:0]                 pad_out,
  output logic      [NUM_PINS-1:0]                 pad_oe,
  output logic      [NUM_PINS-1:0]                 pad_pull_en,
  output logic      [HD_COUNT-1:0]                 pad_high_drive
);

  if (NUM_PINS <= LAST_FIXED_PIN || NUM_PINS > MAX_PINS) begin : g_bad_pins
    $error("NUM_PINS out of supported range");
  end

  typedef struct packed {
    logic [MAX_PINS-1:0] dout;
    logic [MAX_PINS-1:0] dir;
    logic [MAX_PINS-1:0] pull;
    logic [MAX_PINS-1:0] din;
    logic [HD_COUNT-1:0] hdrv;
    logic [31:0]         rdata;
    logic                boot;
  } ppcm_state_t;

  ppcm_state_t         st_q;
  ppcm_state_t         st_d;
  logic [MAX_PINS-1:0] pin_mask;
  logic [MAX_PINS-1:0] pad_in_w;
  logic                apb_setup;
  logic                apb_access;
  ppcm_fn_t            pin_fn  [NUM_PINS];
  logic [NUM_PINS-1:0] oe_req;
  logic [NUM_PINS-1:0] out_req;

  // [RULE_09] Fixed ranking of functions
  function automatic ppcm_fn_t ppcm_owner(input logic [ALT_COUNT-1:0] en);
    if (en[3]) begin
      return PPCM_FN_ALT4;
    end else if (en[2]) begin
      return PPCM_FN_ALT3;
    end else if (en[1]) begin
      return PPCM_FN_ALT2;
    end else if (en[0]) begin
      return PPCM_FN_ALT1;
    end
    return PPCM_FN_PORT;
  endfunction : ppcm_owner

  function automatic logic ppcm_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_DOUT_LO, OFF_DOUT_HI, OFF_DIR_LO, OFF_DIR_HI,
      OFF_PULL_LO, OFF_PULL_HI, OFF_DIN_LO, OFF_DIN_HI,
      OFF_HDRV: return 1'b1;
      default:  return 1'b0;
    endcase
  endfunction : ppcm_mapped

  assign pin_mask   = MAX_PINS'({NUM_PINS{1'b1}});
  assign pad_in_w   = MAX_PINS'(pad_in);
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable;
  // Read data is staged in setup, so no wait state is needed
  assign pready     = 1'b1;
  assign pslverr    = apb_access & ~ppcm_mapped(paddr);
  assign prdata     = st_q.rdata;
  assign periph_in  = st_q.din[NUM_PINS-1:0];

  always_comb begin
    st_d      = st_q;
    st_d.boot = 1'b0;
    // [RULE_11] Sampled input level
    st_d.din  = pad_in_w & pin_mask;
    if (apb_setup) begin
      case (paddr)
        OFF_DOUT_LO: st_d.rdata = st_q.dout[31:0];
        OFF_DOUT_HI: st_d.rdata = st_q.dout[63:32];
        OFF_DIR_LO:  st_d.rdata = st_q.dir[31:0];
        OFF_DIR_HI:  st_d.rdata = st_q.dir[63:32];
        OFF_PULL_LO: st_d.rdata = st_q.pull[31:0];
        OFF_PULL_HI: st_d.rdata = st_q.pull[63:32];
        OFF_DIN_LO:  st_d.rdata = st_q.din[31:0];
        OFF_DIN_HI:  st_d.rdata = st_q.din[63:32];
        OFF_HDRV:    st_d.rdata = {24'h00_0000, st_q.hdrv};
        default:     st_d.rdata = RST_RDATA;
      endcase
    end
    if (apb_access && pwrite) begin
      // Unused pin bits stay zero so readback matches hardware
      case (paddr)
        OFF_DOUT_LO: st_d.dout[31:0]  = pwdata & pin_mask[31:0];
        OFF_DOUT_HI: st_d.dout[63:32] = pwdata & pin_mask[63:32];
        OFF_DIR_LO:  st_d.dir[31:0]   = pwdata & pin_mask[31:0];
        OFF_DIR_HI:  st_d.dir[63:32]  = pwdata & pin_mask[63:32];
        // [RULE_01] Per-bit pull enable
        OFF_PULL_LO: st_d.pull[31:0]  = pwdata & pin_mask[31:0];
        OFF_PULL_HI: st_d.pull[63:32] = pwdata & pin_mask[63:32];
        OFF_HDRV:    st_d.hdrv        = pwdata[HD_COUNT-1:0];
        default:     st_d.boot        = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // [RULE_08] All inputs, no pull-up
      st_q.dout  <= RST_DOUT;
      st_q.dir   <= RST_DIR;
      st_q.pull  <= RST_PULL;
      st_q.din   <= RST_DIN;
      st_q.hdrv  <= RST_HDRV;
      st_q.rdata <= RST_RDATA;
      st_q.boot  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    localparam logic IS_OD = (i == OPEN_DRAIN_DATA_PIN) || (i == OPEN_DRAIN_CLOCK_PIN);
    localparam logic IS_OO = (i == OUTPUT_ONLY_PIN);

    // [RULE_10] Highest enabled function wins
    assign pin_fn[i] = ppcm_owner({alt_en[3][i], alt_en[2][i], alt_en[1][i], alt_en[0][i]});

    always_comb begin
      case (pin_fn[i])
        PPCM_FN_ALT1: begin
          oe_req[i]  = alt_oe[0][i];
          out_req[i] = alt_out[0][i];
        end
        PPCM_FN_ALT2: begin
          oe_req[i]  = alt_oe[1][i];
          out_req[i] = alt_out[1][i];
        end
        PPCM_FN_ALT3: begin
          oe_req[i]  = alt_oe[2][i];
          out_req[i] = alt_out[2][i];
        end
        PPCM_FN_ALT4: begin
          oe_req[i]  = alt_oe[3][i];
          out_req[i] = alt_out[3][i];
        end
        default: begin
          // [RULE_11] Port direction and data
          oe_req[i]  = st_q.dir[i];
          out_req[i] = st_q.dout[i];
        end
      endcase
    end

    ppcm_pad_cell u_cell (
      .oe_req        (oe_req[i]),
      .out_req       (out_req[i]),
      .pull_sel      (st_q.pull[i]),
      .open_drain    (IS_OD),
      .output_only   (IS_OO),
      .two_wire_hold (IS_OD && (pin_fn[i] == TWO_WIRE_FN)),
      .pad_oe        (pad_oe[i]),
      .pad_out       (pad_out[i]),
      .pad_pull      (pad_pull_en[i])
    );
  end

  for (genvar k = 0; k < HD_COUNT; k++) begin : g_hd
    // [RULE_06] Strong drive only while outputting
    assign pad_high_drive[k] = st_q.hdrv[k] & pad_oe[HD_PIN[k]];
  end

  sequence s_pull_write0;
    apb_access && pwrite && (paddr == OFF_PULL_LO);
  endsequence

  sequence s_port_input0;
    (pin_fn[0] == PPCM_FN_PORT) && !st_q.dir[0];
  endsequence

  property p_pull_per_bit;
    @(posedge mclk) disable iff (!rst_n)
      s_pull_write0 ##1 s_port_input0 |-> pad_pull_en[0] == $past(pwdata[0]);
  endproperty
  a_pull_per_bit: assert property (p_pull_per_bit) // [RULE_01]
    else $error("pull enable did not follow write");

  property p_no_pull_out;
    @(posedge mclk) disable iff (!rst_n)
      (pad_oe & pad_pull_en) == '0;
  endproperty
  a_no_pull_out: assert property (p_no_pull_out) // [RULE_02]
    else $error("pull-up on while pin driven");

  property p_pull_periph_in;
    @(posedge mclk) disable iff (!rst_n)
      (pin_fn[HIGH_DRIVE_PIN_H_LOW] != PPCM_FN_PORT) && !oe_req[HIGH_DRIVE_PIN_H_LOW] |->
      pad_pull_en[HIGH_DRIVE_PIN_H_LOW] == st_q.pull[HIGH_DRIVE_PIN_H_LOW];
  endproperty
  a_pull_periph_in: assert property (p_pull_periph_in) // [RULE_03]
    else $error("peripheral input lost pull-up");

  property p_od_low_only;
    @(posedge mclk) disable iff (!rst_n)
      !pad_out[OPEN_DRAIN_DATA_PIN] && !pad_out[OPEN_DRAIN_CLOCK_PIN] &&
      !(out_req[OPEN_DRAIN_DATA_PIN] && pad_oe[OPEN_DRAIN_DATA_PIN]) &&
      !(out_req[OPEN_DRAIN_CLOCK_PIN] && pad_oe[OPEN_DRAIN_CLOCK_PIN]);
  endproperty
  a_od_low_only: assert property (p_od_low_only) // [RULE_04]
    else $error("open-drain pin driven high");

  property p_two_wire_pull;
    @(posedge mclk) disable iff (!rst_n)
      (pin_fn[OPEN_DRAIN_CLOCK_PIN] == TWO_WIRE_FN) && st_q.pull[OPEN_DRAIN_CLOCK_PIN] &&
      oe_req[OPEN_DRAIN_CLOCK_PIN] |->
      pad_pull_en[OPEN_DRAIN_CLOCK_PIN] == out_req[OPEN_DRAIN_CLOCK_PIN];
  endproperty
  a_two_wire_pull: assert property (p_two_wire_pull) // [RULE_05]
    else $error("two-wire pull-up wrong");

  property p_two_wire_data;
    @(posedge mclk) disable iff (!rst_n)
      (pin_fn[OPEN_DRAIN_DATA_PIN] == TWO_WIRE_FN) && st_q.pull[OPEN_DRAIN_DATA_PIN] &&
      oe_req[OPEN_DRAIN_DATA_PIN] |->
      pad_pull_en[OPEN_DRAIN_DATA_PIN] == out_req[OPEN_DRAIN_DATA_PIN];
  endproperty
  a_two_wire_data: assert property (p_two_wire_data) // [RULE_05]
    else $error("two-wire data pull-up wrong");

  property p_high_drive;
    @(posedge mclk) disable iff (!rst_n)
      pad_high_drive[0] == (st_q.hdrv[0] && pad_oe[HIGH_DRIVE_PIN_B_LOW]);
  endproperty
  a_high_drive: assert property (p_high_drive) // [RULE_06]
    else $error("high drive mismatch");

  property p_out_only_pull;
    @(posedge mclk) disable iff (!rst_n)
      !pad_pull_en[OUTPUT_ONLY_PIN];
  endproperty
  a_out_only_pull: assert property (p_out_only_pull) // [RULE_07]
    else $error("output-only pin has pull-up");

  property p_reset_state;
    @(posedge mclk) disable iff (!rst_n)
      st_q.boot && (alt_en == '0) |-> (pad_oe == '0) && (pad_pull_en == '0);
  endproperty
  a_reset_state: assert property (p_reset_state) // [RULE_08]
    else $error("pins not idle after reset");

  property p_alt4_wins;
    @(posedge mclk) disable iff (!rst_n)
      alt_en[3][0] |-> (pin_fn[0] == PPCM_FN_ALT4);
  endproperty
  a_alt4_wins: assert property (p_alt4_wins) // [RULE_09]
    else $error("alternate four not top priority");

  property p_single_owner;
    @(posedge mclk) disable iff (!rst_n)
      alt_en[3][0] && alt_en[0][0] |->
      (pad_out[0] == alt_out[3][0]) && (pad_oe[0] == alt_oe[3][0]);
  endproperty
  a_single_owner: assert property (p_single_owner) // [RULE_10]
    else $error("lower function controls pin");

  property p_input_sample;
    @(posedge mclk) disable iff (!rst_n)
      !st_q.boot |-> periph_in[0] == $past(pad_in[0]);
  endproperty
  a_input_sample: assert property (p_input_sample) // [RULE_11]
    else $error("input data not sampled");

  property p_port_drive;
    @(posedge mclk) disable iff (!rst_n)
      (pin_fn[0] == PPCM_FN_PORT) && st_q.dir[0] |-> pad_oe[0] && (pad_out[0] == st_q.dout[0]);
  endproperty
  a_port_drive: assert property (p_port_drive) // [RULE_11]
    else $error("port output not driven");

  property p_dir_write;
    @(posedge mclk) disable iff (!rst_n)
      apb_access && pwrite && (paddr == OFF_DIR_LO) |=>
      st_q.dir[31:0] == $past(pwdata);
  endproperty
  a_dir_write: assert property (p_dir_write) // [RULE_11]
    else $error("direction write lost");

  // Error only on holes, read data stays zero there
  property p_bus_error;
    @(posedge mclk) disable iff (!rst_n)
      apb_access && !ppcm_mapped(paddr) |-> pslverr && (prdata == RST_RDATA);
  endproperty
  a_bus_error: assert property (p_bus_error)
    else $error("unmapped access not flagged");

endmodule : ppcm_top

// file: rtl/ppcm_pkg.sv
// Function
// [RULE_01] Every pin has its own pull-up enable bit
// [RULE_02] An output pin never has its pull-up on
// [RULE_03] Pull-up also serves a pin used as a peripheral input
// [RULE_04] Open-drain pins only drive low
// [RULE_05] Two-wire unit keeps pull-up, dropped when driving low
// [RULE_06] Eight pins get high drive when outputting
// [RULE_07] 57 pins, one output-only with no pull-up
// [RULE_08] Reset leaves all pins high-Z inputs, no pull-up
// [RULE_09] Priority: port lowest, alternate four highest
// [RULE_10] Highest enabled function alone controls the pin
// [RULE_11] Direction bit, output data, sampled input data
package ppcm_pkg;

  localparam int MAX_PINS  = 64;
  localparam int PIN_COUNT = 57;
  localparam int ALT_COUNT = 4;
  localparam int HD_COUNT  = 8;
  localparam int ADDR_W    = 12;

  // Byte offsets of the APB registers
  localparam logic [ADDR_W-1:0] OFF_DOUT_LO = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_DOUT_HI = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_DIR_LO  = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_DIR_HI  = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_PULL_LO = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_PULL_HI = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_DIN_LO  = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_DIN_HI  = 12'h01c;
  localparam logic [ADDR_W-1:0] OFF_HDRV    = 12'h020;

  localparam logic [MAX_PINS-1:0] RST_DOUT = 64'h0000_0000_0000_0000;
  localparam logic [MAX_PINS-1:0] RST_DIR  = 64'h0000_0000_0000_0000;
  localparam logic [MAX_PINS-1:0] RST_PULL = 64'h0000_0000_0000_0000;
  localparam logic [MAX_PINS-1:0] RST_DIN  = 64'h0000_0000_0000_0000;
  localparam logic [HD_COUNT-1:0] RST_HDRV = 8'h00;
  localparam logic [31:0]         RST_RDATA = 32'h0000_0000;

  // Pin indices: port A bits 0..7, B 8..15, C 16..23, D 24..31,
  // E 32..39, F 40..47, G 48..51, H0 H1 H2 H6 H7 at 52..56
  localparam int OPEN_DRAIN_DATA_PIN   = 2;
  localparam int OPEN_DRAIN_CLOCK_PIN  = 3;
  localparam int OUTPUT_ONLY_PIN       = 4;
  localparam int HIGH_DRIVE_PIN_B_LOW  = 12;
  localparam int HIGH_DRIVE_PIN_B_HIGH = 13;
  localparam int HIGH_DRIVE_PIN_D_LOW  = 24;
  localparam int HIGH_DRIVE_PIN_D_HIGH = 25;
  localparam int HIGH_DRIVE_PIN_E_LOW  = 32;
  localparam int HIGH_DRIVE_PIN_E_HIGH = 33;
  localparam int HIGH_DRIVE_PIN_H_LOW  = 52;
  localparam int HIGH_DRIVE_PIN_H_HIGH = 53;
  localparam int LAST_FIXED_PIN        = 53;

  localparam int HD_PIN [HD_COUNT] = '{
    HIGH_DRIVE_PIN_B_LOW, HIGH_DRIVE_PIN_B_HIGH,
    HIGH_DRIVE_PIN_D_LOW, HIGH_DRIVE_PIN_D_HIGH,
    HIGH_DRIVE_PIN_E_LOW, HIGH_DRIVE_PIN_E_HIGH,
    HIGH_DRIVE_PIN_H_LOW, HIGH_DRIVE_PIN_H_HIGH
  };

  typedef enum logic [2:0] {
    PPCM_FN_PORT = 3'h0,
    PPCM_FN_ALT1 = 3'h1,
    PPCM_FN_ALT2 = 3'h2,
    PPCM_FN_ALT3 = 3'h3,
    PPCM_FN_ALT4 = 3'h4
  } ppcm_fn_t;

  // Alternate three of the open-drain pins is the two_wire_bus_unit
  localparam ppcm_fn_t TWO_WIRE_FN = PPCM_FN_ALT3;

endpackage : ppcm_pkg

// file: rtl/ppcm_pad_cell.sv
`timescale 1ns/1ps
module ppcm_pad_cell
  import ppcm_pkg::*;
(
  input  wire logic oe_req,
  input  wire logic out_req,
  input  wire logic pull_sel,
  input  wire logic open_drain,
  input  wire logic output_only,
  input  wire logic two_wire_hold,
  output logic      pad_oe,
  output logic      pad_out,
  output logic      pad_pull
);

  always_comb begin
    // [RULE_04] Low-only drive
    pad_out = open_drain ? 1'b0 : out_req;
    pad_oe  = open_drain ? (oe_req & ~out_req) : oe_req;
    if (output_only) begin
      // [RULE_07] No pull-up here
      pad_pull = 1'b0;
    end else if (two_wire_hold && oe_req) begin
      // [RULE_05] Pull-up dropped on low
      pad_pull = pull_sel & out_req;
    end else begin
      // [RULE_01] [RULE_02] [RULE_03] Input-only pull-up
      pad_pull = pull_sel & ~oe_req;
    end
  end

endmodule : ppcm_pad_cell

// file: testbench/ppcm_board_model.sv
`timescale 1ns/1ps
module ppcm_board_model #(
  parameter int N = 57
) (
  input  wire logic         mclk,
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  input  wire logic [N-1:0] pad_pull_en,
  input  wire logic [N-1:0] ext_en,
  input  wire logic [N-1:0] ext_val,
  output logic      [N-1:0] pad_in
);
  logic [N-1:0] last_q = '0;

  // Floating pins wander instead of holding a handy value
  always_ff @(posedge mclk) begin
    last_q <= pad_in;
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pull_en[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ~last_q[i];
      end
    end
  end
endmodule : ppcm_board_model

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import ppcm_pkg::*;
  localparam int N = PIN_COUNT;
  localparam int P = HIGH_DRIVE_PIN_H_LOW;
  localparam int D = OPEN_DRAIN_DATA_PIN;
  localparam int C = OPEN_DRAIN_CLOCK_PIN;
  logic                        mclk = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        psel = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite = 1'b0;
  logic [ADDR_W-1:0]           paddr = '0;
  logic [31:0]                 pwdata = '0;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic [ALT_COUNT-1:0][N-1:0] alt_en = '0;
  logic [ALT_COUNT-1:0][N-1:0] alt_oe = '0;
  logic [ALT_COUNT-1:0][N-1:0] alt_out = '0;
  logic [N-1:0]                periph_in;
  logic [N-1:0]                pad_in;
  logic [N-1:0]                pad_out;
  logic [N-1:0]                pad_oe;
  logic [N-1:0]                pad_pull_en;
  logic [N-1:0]                ext_en = '0;
  logic [N-1:0]                ext_val = '0;
  logic [HD_COUNT-1:0]         pad_high_drive;
  logic [31:0]                 rd;
  logic                        err;
  int                          mismatches = 0;
  int                          checks = 0;
  int                          cyc = 0;

  always #50 mclk = ~mclk;

  ppcm_top #(.NUM_PINS(N)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alt_en(alt_en), .alt_oe(alt_oe), .alt_out(alt_out),
    .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_en(pad_pull_en), .pad_high_drive(pad_high_drive)
  );

  ppcm_board_model #(.N(N)) i_board (
    .mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
  );

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      $display("[ERR] %0t %s", $time, m);
      mismatches++;
    end
  endtask : chk

  // Holds the request until pready is seen high at a rising edge or 20 edges have passed
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    chk(pready, 1'b1, "no bus answer");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_reset;
    @(negedge mclk);
    chk(pad_oe, '0, "pins driven after reset");
    chk(pad_pull_en, '0, "pull-ups on after reset");
    chk(pad_high_drive, '0, "high drive after reset");
    apb(1'b0, OFF_DIR_LO, '0, rd, err);
    chk(rd, '0, "direction not input after reset");
  endtask : t_reset

  task automatic t_port;
    apb(1'b1, OFF_PULL_LO, 32'hc3c3_5a5e, rd, err);
    apb(1'b1, OFF_PULL_HI, 32'h01ff_ffff, rd, err);
    @(negedge mclk);
    chk(pad_pull_en, {25'h1ff_ffff, 32'hc3c3_5a4e}, "per-pin pull");
    apb(1'b1, OFF_DIR_LO, 32'hffff_ffff, rd, err);
    @(negedge mclk);
    chk(pad_pull_en, {25'h1ff_ffff, 32'h0}, "pull kept on outputs");
    chk(pad_oe, {25'h0, 32'hffff_ffff}, "outputs not driven");
    apb(1'b1, OFF_DOUT_LO, 32'h8001_00fc, rd, err);
    @(negedge mclk);
    chk(pad_out, {25'h0, 32'h8001_00f0}, "output values");
    chk(pad_oe, {25'h0, 32'hffff_fff3}, "open-drain drove high");
    @(posedge mclk);
    ext_en <= {25'h1ff_ffff, 32'h0};
    ext_val <= {25'h1a5_c33c, 32'h0};
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(periph_in[56:32], 25'h1a5_c33c, "peripheral input level");
    apb(1'b0, OFF_DIN_HI, '0, rd, err);
    chk(rd, {7'h0, 25'h1a5_c33c}, "input data read");
  endtask : t_port

  task automatic t_two_wire;
    @(posedge mclk);
    alt_en[TWO_WIRE_FN - 1][D] <= 1'b1;
    alt_oe[TWO_WIRE_FN - 1][D] <= 1'b1;
    alt_out[TWO_WIRE_FN - 1][D] <= 1'b1;
    alt_en[TWO_WIRE_FN - 1][C] <= 1'b1;
    alt_oe[TWO_WIRE_FN - 1][C] <= 1'b1;
    alt_out[TWO_WIRE_FN - 1][C] <= 1'b1;
    @(negedge mclk);
    chk({pad_pull_en[C], pad_oe[C], pad_out[C], pad_pull_en[D], pad_oe[D], pad_out[D]},
        6'b100_100, "bus high");
    @(posedge mclk);
    alt_out[TWO_WIRE_FN - 1][D] <= 1'b0;
    @(negedge mclk);
    chk({pad_pull_en[C], pad_oe[C], pad_out[C], pad_pull_en[D], pad_oe[D], pad_out[D]},
        6'b100_010, "data low");
    @(posedge mclk);
    alt_out[TWO_WIRE_FN - 1][C] <= 1'b0;
    @(negedge mclk);
    chk({pad_pull_en[C], pad_oe[C], pad_out[C]}, 3'b010, "clock low");
    @(posedge mclk);
    alt_en <= '0;
  endtask : t_two_wire

  task automatic t_priority;
    apb(1'b1, OFF_HDRV, 32'h0000_00ff, rd, err);
    @(negedge mclk);
    chk(pad_high_drive, 8'h0f, "high drive on outputs");
    for (int k = 0; k < ALT_COUNT; k++) begin
      @(posedge mclk);
      for (int j = 0; j < ALT_COUNT; j++) begin
        alt_en[j][P] <= (j <= k);
        alt_oe[j][P] <= 1'b1;
        alt_out[j][P] <= (j == k);
        alt_en[j][0] <= (j <= k);
        alt_oe[j][0] <= 1'b1;
        alt_out[j][0] <= (j == k);
      end
      @(negedge mclk);
      chk({pad_out[0], pad_oe[0], pad_out[P], pad_oe[P], pad_pull_en[P], pad_high_drive},
          {5'b11110, 8'h4f}, "owner not highest alternate");
    end
    @(posedge mclk);
    alt_oe[3][P] <= 1'b0;
    @(negedge mclk);
    chk({pad_oe[P], pad_pull_en[P], pad_high_drive}, {2'b01, 8'h0f},
        "peripheral input pull");
    @(posedge mclk);
    alt_en <= '0;
  endtask : t_priority

  task automatic t_unmapped;
    apb(1'b0, 12'h040, '0, rd, err);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
    apb(1'b1, 12'h024, 32'hffff_ffff, rd, err);
    chk(err, 1'b1, "unmapped write");
  endtask : t_unmapped

  task automatic t_readback;
    apb(1'b1, OFF_DOUT_HI, 32'hffff_ffff, rd, err);
    apb(1'b0, OFF_DOUT_HI, '0, rd, err);
    chk({err, rd}, {1'b0, 32'h01ff_ffff}, "unused pin bits kept");
    apb(1'b1, OFF_DIR_HI, 32'h0000_0003, rd, err);
    @(negedge mclk);
    chk({pad_out[33:32], pad_oe[33:32], pad_high_drive}, {4'hf, 8'h3f},
        "high word outputs");
    apb(1'b0, OFF_HDRV, '0, rd, err);
    chk({err, rd}, {1'b0, 32'h0000_00ff}, "high drive readback");
  endtask : t_readback

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_port();
    t_two_wire();
    t_priority();
    t_unmapped();
    t_readback();
    report_and_stop();
  end
endmodule : tb
